// ===== dhr_regs.svh
// Purpose: Register offsets, field positions and reset values of the transfer controller.
// Assumes: Byte addresses on a 32-bit AXI4-Lite bus, one register per aligned word.
// Notes: Definitions only.
`ifndef DHR_REGS_SVH
`define DHR_REGS_SVH
`define DHR_OFF_CTRL 8'h00
`define DHR_OFF_MADDR 8'h04
`define DHR_OFF_IOADDR 8'h08
`define DHR_OFF_COUNT 8'h0C
`define DHR_OFF_BLOCK 8'h10
`define DHR_OFF_STATUS 8'h14
`define DHR_OFF_MASK 8'h18
`define DHR_CTRL_CE 0
`define DHR_CTRL_ME 1
`define DHR_CTRL_WORD 2
`define DHR_CTRL_WIDE 3
`define DHR_CTRL_DIR 4
`define DHR_CTRL_BLOCK 5
`define DHR_ST_DONE 0
`define DHR_ST_NMI 1
`define DHR_ST_DROP 2
`define DHR_ST_W 3
`define DHR_ST_RESET 3'h0
`define DHR_MADDR_RESET 24'h000000
`define DHR_MASK_1M 24'h0FFFFF
`define DHR_IO_TOP_16M 16'hFFFF
`define DHR_IO_TOP_1M 16'h0FFF
`define DHR_RESP_OKAY 2'h0
`define DHR_RESP_SLVERR 2'h2
`endif

// ===== dhr_pkg.sv
// Purpose: Types shared by the transfer controller.
// Assumes: Nothing beyond the register header.
// Notes: Engine states only; constants live in the header.
package dhr_pkg;
    // Engine states: waiting for a request, source read, destination write.
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} dhr_state_t;
endpackage

// ===== dhr_dma.sv
// Purpose: Full address mode transfer channel with NMI halt, resume and abort handling.
// Assumes: One clock, synchronous active-high reset, AXI4-Lite register slave.
// Notes: Contract
// Contract
// - Long memory address access as four bytes.
// - Channel set, master clear blocks CPU interrupt.
// - NMI finishes unit, clears master, halts.
// - Block counter keeps progress after halt.
// - Mid-block halt clears activating flag.
// - Halted state drops requests, no CPU interrupt.
// - Resume finishes block on next request.
// - 1-Mbyte mode ignores address bits 23:20.
// - Abort with pending request gives dead cycle.
// - Channel runs only with both enables set.
// - Clearing channel enable halts after unit.
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "dhr_regs.svh"
module dhr_dma
    import dhr_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int BLK_W = 8
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic nmiPin,
    input wire logic actFlag,
    output logic actFlagClr,
    output logic cpuIrq,
    output logic busReq,
    input wire logic busGnt,
    output logic [23:0] busAddr,
    output logic busWrite,
    output logic busWord,
    output logic [15:0] busWdata,
    input wire logic [15:0] busRdata,
    output logic busDead,
    output logic irq
);
    // Control fields.
    logic chanEn;
    logic mastEn;
    logic wordSize;
    logic wideMode;
    logic dirIoToMem;
    logic blockMode;
    // Address, count and block registers.
    logic [23:0] memAddr;
    logic [7:0] ioAddr;
    logic [CNT_W-1:0] xferCnt;
    logic [BLK_W-1:0] blkInit;
    logic [BLK_W-1:0] blkLeft;
    // Interrupt status and mask.
    logic [`DHR_ST_W-1:0] status;
    logic [`DHR_ST_W-1:0] mask;
    logic [`DHR_ST_W-1:0] events;
    // Engine state.
    dhr_state_t state;
    logic pending;
    logic actPrev;
    logic nmiMeta;
    logic nmiSync;
    logic nmiPrev;
    // Byte sequencer for memory address accesses.
    logic seqActive;
    logic seqWrite;
    logic [1:0] seqStep;
    logic [31:0] seqData;
    logic [3:0] seqStrb;
    logic [31:0] seqRd;
    // Combinational helpers.
    logic run;
    logic nmiHit;
    logic actRise;
    logic unitDone;
    logic blockEnd;
    logic midHalt;
    logic wrAccept;
    logic rdAccept;
    logic seqHold;
    logic seqLast;
    logic [1:0] lane;
    logic [23:0] memEff;
    logic [23:0] ioEff;
    logic [31:0] rdMux;
    logic rdErr;
    logic wrErr;

    // The channel only starts a unit while both enables are set.
    assign run = chanEn && mastEn;
    assign nmiHit = nmiSync && !nmiPrev;
    assign actRise = actFlag && !actPrev;
    assign unitDone = (state == ST_WRITE) && busGnt;
    assign blockEnd = !blockMode || (blkLeft == BLK_W'(1));
    // A halt inside a block leaves the remainder for the next request.
    assign midHalt = unitDone && !blockEnd && !run;
    // The source may interrupt the CPU only while the channel is disabled.
    assign cpuIrq = actFlag && !chanEn;
    // In 1-Mbyte mode the top address nibble is dropped.
    assign memEff = wideMode ? memAddr : (memAddr & `DHR_MASK_1M);
    // The I/O side always lands in the topmost 256-byte page.
    assign ioEff = wideMode ? {`DHR_IO_TOP_16M, ioAddr} : {`DHR_IO_TOP_1M, ioAddr};
    assign busReq = (state != ST_IDLE);
    assign busWrite = (state == ST_WRITE);
    assign busWord = wordSize;
    assign busAddr = ((state == ST_READ) == dirIoToMem) ? ioEff : memEff;
    assign irq = |(status & mask);
    // Writes are taken with address and data together, one at a time.
    // No handshake is offered while the clock enable freezes the registers.
    assign wrAccept = clkEn && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !seqActive;
    assign rdAccept = clkEn && s_axi_arvalid && !s_axi_rvalid && !seqActive && !wrAccept;
    assign s_axi_awready = wrAccept;
    assign s_axi_wready = wrAccept;
    assign s_axi_arready = rdAccept;
    // Lanes go top byte first; the bus may be lent out before the third.
    assign lane = ~seqStep;
    assign seqHold = seqActive && (seqStep == 2'h2) && busReq;
    assign seqLast = seqActive && (seqStep == 2'h3);
    assign wrErr = (s_axi_awaddr > `DHR_OFF_MASK) || (s_axi_awaddr[1:0] != 2'h0);

    // Event sources for the sticky status bits.
    always_comb
    begin
        events = '0;
        events[`DHR_ST_DONE] = unitDone && blockEnd && (xferCnt == CNT_W'(1));
        events[`DHR_ST_NMI] = nmiHit && run;
        events[`DHR_ST_DROP] = actRise && chanEn && !mastEn;
    end

    // Register read multiplexer; unmapped offsets answer with an error.
    always_comb
    begin
        rdMux = 32'h0;
        rdErr = 1'b0;
        case (s_axi_araddr)
            `DHR_OFF_CTRL:
            begin
                rdMux[`DHR_CTRL_CE] = chanEn;
                rdMux[`DHR_CTRL_ME] = mastEn;
                rdMux[`DHR_CTRL_WORD] = wordSize;
                rdMux[`DHR_CTRL_WIDE] = wideMode;
                rdMux[`DHR_CTRL_DIR] = dirIoToMem;
                rdMux[`DHR_CTRL_BLOCK] = blockMode;
            end
            `DHR_OFF_IOADDR: rdMux[7:0] = ioAddr;
            `DHR_OFF_COUNT: rdMux[CNT_W-1:0] = xferCnt;
            // Progress sits above the initial size so software can spot a split block.
            `DHR_OFF_BLOCK: rdMux[2*BLK_W-1:0] = {blkLeft, blkInit};
            `DHR_OFF_STATUS: rdMux[`DHR_ST_W-1:0] = status;
            `DHR_OFF_MASK: rdMux[`DHR_ST_W-1:0] = mask;
            default: rdErr = 1'b1;
        endcase
    end

    // Synchronise the NMI pin; only the second stage and its delayed copy feed logic.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            nmiMeta <= 1'b0;
            nmiSync <= 1'b0;
            nmiPrev <= 1'b0;
            actPrev <= 1'b0;
        end
        else if (clkEn)
        begin
            nmiMeta <= nmiPin;
            nmiSync <= nmiMeta;
            nmiPrev <= nmiSync;
            actPrev <= actFlag;
        end
    end

    // Control register; hardware clears override software writes.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            chanEn <= 1'b0;
            mastEn <= 1'b0;
            wordSize <= 1'b0;
            wideMode <= 1'b0;
            dirIoToMem <= 1'b0;
            blockMode <= 1'b0;
            ioAddr <= 8'h00;
            mask <= '0;
        end
        else if (clkEn)
        begin
            if (wrAccept && s_axi_wstrb[0])
            begin
                // Software setup of control, I/O address and mask.
                if (s_axi_awaddr == `DHR_OFF_CTRL)
                begin
                    chanEn <= s_axi_wdata[`DHR_CTRL_CE];
                    mastEn <= s_axi_wdata[`DHR_CTRL_ME];
                    wordSize <= s_axi_wdata[`DHR_CTRL_WORD];
                    wideMode <= s_axi_wdata[`DHR_CTRL_WIDE];
                    dirIoToMem <= s_axi_wdata[`DHR_CTRL_DIR];
                    blockMode <= s_axi_wdata[`DHR_CTRL_BLOCK];
                end
                if (s_axi_awaddr == `DHR_OFF_IOADDR)
                    ioAddr <= s_axi_wdata[7:0];
                if (s_axi_awaddr == `DHR_OFF_MASK)
                    mask <= s_axi_wdata[`DHR_ST_W-1:0];
            end
            // Final transfer done: the channel disables itself.
            if (events[`DHR_ST_DONE])
                chanEn <= 1'b0;
            // NMI drops the master enable whatever software writes.
            if (nmiHit)
                mastEn <= 1'b0;
        end
    end

    // Sticky status; a read clears it but a same-cycle event still sets.
    always_ff @(posedge clk)
    begin
        if (rst)
            status <= `DHR_ST_RESET;
        else if (clkEn)
        begin
            if (rdAccept && (s_axi_araddr == `DHR_OFF_STATUS))
                status <= events;
            else
                status <= status | events;
        end
    end

    // Transfer engine: request capture, read/write pair, counters.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state <= ST_IDLE;
            pending <= 1'b0;
            busWdata <= 16'h0000;
            xferCnt <= '0;
            blkInit <= '0;
            blkLeft <= '0;
            actFlagClr <= 1'b0;
            busDead <= 1'b0;
        end
        else if (clkEn)
        begin
            actFlagClr <= 1'b0;
            busDead <= 1'b0;
            // Requests count only while running and idle; others are lost.
            if (actRise && run && (state == ST_IDLE))
                pending <= 1'b1;
            // Halt with a request still pending: one dead cycle, no update.
            if ((state == ST_IDLE) && pending && !run)
            begin
                pending <= 1'b0;
                busDead <= 1'b1;
            end
            unique case (state)
                ST_IDLE:
                begin
                    // Resume continues from the kept block progress.
                    if (run && pending)
                    begin
                        state <= ST_READ;
                        pending <= 1'b0;
                    end
                end
                ST_READ:
                begin
                    // The unit always completes once started.
                    if (busGnt)
                    begin
                        busWdata <= busRdata;
                        state <= ST_WRITE;
                    end
                end
                ST_WRITE:
                begin
                    if (busGnt)
                    begin
                        blkLeft <= blockEnd ? blkInit : blkLeft - BLK_W'(1);
                        if (blockEnd)
                            xferCnt <= xferCnt - CNT_W'(1);
                        // Stop at block end, or after this unit if halted.
                        state <= (blockEnd || !run) ? ST_IDLE : ST_READ;
                        actFlagClr <= blockEnd || !run;
                    end
                end
            endcase
            // Software loads count and block size while halted.
            if (wrAccept && (s_axi_awaddr == `DHR_OFF_COUNT))
            begin
                if (s_axi_wstrb[0])
                    xferCnt[7:0] <= s_axi_wdata[7:0];
                if (s_axi_wstrb[1])
                    xferCnt[CNT_W-1:8] <= s_axi_wdata[CNT_W-1:8];
            end
            if (wrAccept && s_axi_wstrb[0] && (s_axi_awaddr == `DHR_OFF_BLOCK))
            begin
                blkInit <= s_axi_wdata[BLK_W-1:0];
                blkLeft <= s_axi_wdata[BLK_W-1:0];
            end
        end
    end

    // Memory address: byte writes from the sequencer, else unit increments.
    always_ff @(posedge clk)
    begin
        if (rst)
            memAddr <= `DHR_MADDR_RESET;
        else if (clkEn)
        begin
            if (seqActive && !seqHold && seqWrite && seqStrb[lane] && (lane != 2'h3))
                memAddr[{lane, 3'h0} +: 8] <= seqData[{lane, 3'h0} +: 8];
            else if (unitDone)
                memAddr <= memAddr + (wordSize ? 24'h000002 : 24'h000001);
        end
    end

    // Long access to the memory address splits into four byte steps.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            seqActive <= 1'b0;
            seqWrite <= 1'b0;
            seqStep <= 2'h0;
            seqData <= 32'h0;
            seqStrb <= 4'h0;
            seqRd <= 32'h0;
        end
        else if (clkEn)
        begin
            if (!seqActive)
            begin
                if (wrAccept && (s_axi_awaddr == `DHR_OFF_MADDR))
                begin
                    seqActive <= 1'b1;
                    seqWrite <= 1'b1;
                    seqData <= s_axi_wdata;
                    seqStrb <= s_axi_wstrb;
                end
                else if (rdAccept && (s_axi_araddr == `DHR_OFF_MADDR))
                begin
                    seqActive <= 1'b1;
                    seqWrite <= 1'b0;
                end
                seqStep <= 2'h0;
            end
            else if (!seqHold)
            begin
                // Top lane is unused and reads as zero.
                seqRd[{lane, 3'h0} +: 8] <= (lane == 2'h3) ? 8'h00 : memAddr[{lane, 3'h0} +: 8];
                seqStep <= seqStep + 2'h1;
                if (seqLast)
                    seqActive <= 1'b0;
            end
        end
    end

    // AXI response channels.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DHR_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `DHR_RESP_OKAY;
            s_axi_rdata <= 32'h0;
        end
        else if (clkEn)
        begin
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            // Plain registers answer on the next edge.
            if (wrAccept && (s_axi_awaddr != `DHR_OFF_MADDR))
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrErr ? `DHR_RESP_SLVERR : `DHR_RESP_OKAY;
            end
            if (rdAccept && (s_axi_araddr != `DHR_OFF_MADDR))
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdMux;
                s_axi_rresp <= rdErr ? `DHR_RESP_SLVERR : `DHR_RESP_OKAY;
            end
            // The memory address answers after its fourth byte step.
            if (seqLast && !seqHold)
            begin
                if (seqWrite)
                begin
                    s_axi_bvalid <= 1'b1;
                    s_axi_bresp <= `DHR_RESP_OKAY;
                end
                else
                begin
                    s_axi_rvalid <= 1'b1;
                    s_axi_rresp <= `DHR_RESP_OKAY;
                    s_axi_rdata <= {seqRd[31:8], memAddr[7:0]};
                end
            end
        end
    end

    // NMI must remove the master enable on the following edge.
    property p_nmi_clears;
        @(posedge clk) disable iff (rst || !clkEn) nmiHit |=> !mastEn;
    endproperty
    a_nmi_clears: assert property (p_nmi_clears) else $error("NMI left master enable set");

    // No transfer may start unless both enables are set.
    property p_run_gate;
        @(posedge clk) disable iff (rst || !clkEn) (state == ST_IDLE && !run) |=> state == ST_IDLE;
    endproperty
    a_run_gate: assert property (p_run_gate) else $error("Transfer started while disabled");

    // Channel set with master clear keeps the CPU interrupt off.
    property p_irq_block;
        @(posedge clk) disable iff (rst) (chanEn && !mastEn) |-> !cpuIrq;
    endproperty
    a_irq_block: assert property (p_irq_block) else $error("CPU interrupt while halted");

    // A request while halted is not stored.
    property p_drop;
        @(posedge clk) disable iff (rst || !clkEn) (actRise && chanEn && !mastEn && !pending)
            |=> !pending ##1 state == ST_IDLE;
    endproperty
    a_drop: assert property (p_drop) else $error("Halted request was kept");

    // A mid-block halt clears the activating flag and returns to idle.
    property p_mid_halt;
        @(posedge clk) disable iff (rst || !clkEn) midHalt |=> actFlagClr && state == ST_IDLE;
    endproperty
    a_mid_halt: assert property (p_mid_halt) else $error("Mid-block halt mishandled");

    // Narrow mode never drives the top address nibble.
    property p_narrow;
        @(posedge clk) disable iff (rst) (busReq && !wideMode) |-> busAddr[23:20] == 4'h0;
    endproperty
    a_narrow: assert property (p_narrow) else $error("Address bits 23:20 driven");

    // The I/O phase addresses the top page.
    property p_io_page;
        @(posedge clk) disable iff (rst) (busReq && ((state == ST_READ) == dirIoToMem))
            |-> busAddr[19:8] == 12'hFFF;
    endproperty
    a_io_page: assert property (p_io_page) else $error("I/O address outside top page");

    // The dead cycle leaves address and counters untouched.
    property p_dead;
        @(posedge clk) disable iff (rst || !clkEn) busDead |-> $stable(memAddr) && $stable(blkLeft)
            && $stable(xferCnt);
    endproperty
    a_dead: assert property (p_dead) else $error("Dead cycle changed counters");

    // Clearing the channel enable mid-read still finishes the write.
    property p_abort_unit;
        @(posedge clk) disable iff (rst || !clkEn) ($fell(chanEn) && state == ST_READ && busGnt)
            |=> state == ST_WRITE;
    endproperty
    a_abort_unit: assert property (p_abort_unit) else $error("Unit cut short on abort");

    // The byte sequence waits between its second and third step while the bus is lent.
    property p_seq_hold;
        @(posedge clk) disable iff (rst || !clkEn) seqHold |=> seqStep == 2'h2;
    endproperty
    a_seq_hold: assert property (p_seq_hold) else $error("Byte step ran while bus lent");
endmodule

// ===== dhr_bus_model.sv
// Purpose: System bus model that grants engine cycles and serves reads.
// Assumes: One clock shared with the transfer controller.
// Notes: Grants stall at random while slow is high.
`timescale 1ns/1ps
module dhr_bus_model
(
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic busReq,
    input wire logic busWrite,
    input wire logic [23:0] busAddr,
    output logic busGnt,
    output logic [15:0] busRdata
);
    logic [1:0] waitCnt; // Cycles left before the next grant.
    logic [15:0] lastData; // Value on the read-data lines at the last grant, read or write.
    // A phase is granted once its stall count has run out.
    assign busGnt = busReq && (waitCnt == 2'h0);
    // Released lines show the inverse of the last value, never a stale copy.
    assign busRdata = (busReq && !busWrite) ? (busAddr[15:0] ^ 16'h5A3C) : ~lastData;
    // A fresh random stall is loaded after every grant while slow is high, else zero.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            waitCnt <= 2'h0;
            lastData <= 16'h0000;
        end
        else if (busGnt)
        begin
            waitCnt <= slow ? 2'($urandom_range(3)) : 2'h0;
            lastData <= busRdata;
        end
        else if (busReq)
        begin
            waitCnt <= waitCnt - 2'h1;
        end
    end
endmodule

// ===== test_dhr_dma.sv
// Purpose: Self-checking bench for the transfer controller.
// Assumes: Registers reached over AXI4-Lite, bus served by the bus model.
// Notes: Random single units, a dropped request, an NMI halt and resume.
`timescale 1ns/1ps
`include "dhr_regs.svh"
module test_dhr_dma import dhr_pkg::*;;
    logic clk = 1'b0, rst = 1'b1, slow = 1'b0, nmiPin = 1'b0, actFlag = 1'b0, chk = 1'b1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, io;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic actFlagClr, cpuIrq, busReq, busGnt, busWrite, busWord, busDead, irq, word, wide;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [23:0] busAddr, expSrc, expDst, rdAddr, ma;
    logic [15:0] busWdata, busRdata, msk;
    int num_errors = 0, compares = 0, units = 0, u0, deads = 0;
    // Free-running 20 MHz clock.
    always #25 clk = ~clk;
    dhr_dma #(.CNT_W(16), .BLK_W(8)) u_dut (.clk, .rst, .clkEn(1'b1),
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .nmiPin, .actFlag, .actFlagClr, .cpuIrq, .busReq,
        .busGnt, .busAddr, .busWrite, .busWord, .busWdata, .busRdata, .busDead, .irq);
    dhr_bus_model u_bus (.clk, .rst, .slow, .busReq, .busWrite, .busAddr, .busGnt, .busRdata);
    // Model data seen at a bus address.
    function automatic logic [15:0] memWord(input logic [23:0] a);
        return a[15:0] ^ 16'h5A3C;
    endfunction
    // Counts a comparison and reports a mismatch.
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One register write; both channels offered together and held until taken.
    // Response ready is set high on every call and never lowered, so it stays high between calls.
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge clk); while (!(s_axi_awready && s_axi_wready));
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_bvalid);
        check("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask
    // One register read; data taken at the handshake edge.
    task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        v = s_axi_rdata;
        check("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask
    // Waits, bounded, for the clear pulse to the activating source.
    task automatic waitClr();
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (actFlagClr !== 1'b1 && n < 300);
        check("actFlagClr", 32'h1, {31'h0, actFlagClr});
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Checks write data on every granted write; addresses only while chk is set.
    always @(posedge clk)
    begin
        msk = busWord ? 16'hFFFF : 16'h00FF;
        if (!rst && busGnt && !busWrite && chk)
            check("read addr", {8'h0, expSrc}, {8'h0, busAddr});
        if (!rst && busGnt && busWrite)
        begin
            if (chk)
                check("write addr", {8'h0, expDst}, {8'h0, busAddr});
            check("write data", {16'h0, memWord(rdAddr) & msk}, {16'h0, busWdata & msk});
            units++;
        end
        if (busGnt && !busWrite)
            rdAddr = busAddr;
        // Counts dead bus cycles of an aborted pending request.
        if (!rst && busDead)
            deads++;
    end
    // Cuts a hang short.
    initial
    begin
        #(50ns * 40000);
        num_errors++;
        tally_and_finish();
    end
    // Main sequence.
    initial
    begin
        void'($urandom(32'hADEE));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`DHR_OFF_STATUS, `DHR_RESP_OKAY, d);
        check("status reset", 32'h0, d);
        rd(8'h1C, `DHR_RESP_SLVERR, d);
        check("unmapped", 32'h0, d);
        wr(8'h02, 32'h3, `DHR_RESP_SLVERR);
        wr(`DHR_OFF_MASK, 32'h7, `DHR_RESP_OKAY);
        repeat (6)
        begin
            word = 1'($urandom_range(1));
            wide = 1'($urandom_range(1));
            ma = 24'($urandom) & (word ? 24'hFFFFFE : 24'hFFFFFF);
            io = 8'($urandom) & (word ? 8'hFE : 8'hFF);
            slow <= 1'($urandom_range(1));
            expSrc = wide ? ma : (ma & `DHR_MASK_1M);
            expDst = wide ? {`DHR_IO_TOP_16M, io} : {`DHR_IO_TOP_1M, io};
            wr(`DHR_OFF_MADDR, {8'h0, ma}, `DHR_RESP_OKAY);
            wr(`DHR_OFF_IOADDR, {24'h0, io}, `DHR_RESP_OKAY);
            wr(`DHR_OFF_COUNT, 32'h1, `DHR_RESP_OKAY);
            wr(`DHR_OFF_CTRL, {28'h0, wide, word, 2'h3}, `DHR_RESP_OKAY);
            actFlag <= 1'b1;
            waitClr();
            actFlag <= 1'b0;
            check("irq done", 32'h1, {31'h0, irq});
            rd(`DHR_OFF_STATUS, `DHR_RESP_OKAY, d);
            check("status done", 32'h1, d);
            rd(`DHR_OFF_MADDR, `DHR_RESP_OKAY, d);
            check("maddr step", {12'h0, 20'(ma[19:0] + (word ? 20'h2 : 20'h1))}, {12'h0, d[19:0]});
        end
        wr(`DHR_OFF_COUNT, 32'h1, `DHR_RESP_OKAY);
        wr(`DHR_OFF_CTRL, 32'h9, `DHR_RESP_OKAY);
        u0 = units;
        actFlag <= 1'b1;
        repeat (6) @(posedge clk);
        check("cpuIrq held", 32'h0, {31'h0, cpuIrq});
        check("no unit", 32'(u0), 32'(units));
        rd(`DHR_OFF_STATUS, `DHR_RESP_OKAY, d);
        check("status drop", 32'h4, d);
        wr(`DHR_OFF_CTRL, 32'h8, `DHR_RESP_OKAY);
        check("cpuIrq free", 32'h1, {31'h0, cpuIrq});
        actFlag <= 1'b0;
        chk <= 1'b0;
        slow <= 1'b1;
        wr(`DHR_OFF_BLOCK, 32'h8, `DHR_RESP_OKAY);
        wr(`DHR_OFF_COUNT, 32'h1, `DHR_RESP_OKAY);
        wr(`DHR_OFF_CTRL, 32'h2B, `DHR_RESP_OKAY);
        u0 = units;
        actFlag <= 1'b1;
        while (units == u0) @(posedge clk);
        nmiPin <= 1'b1;
        repeat (2) @(posedge clk);
        nmiPin <= 1'b0;
        waitClr();
        actFlag <= 1'b0;
        repeat (4) @(posedge clk);
        check("halted", 32'h0, {31'h0, busReq});
        rd(`DHR_OFF_CTRL, `DHR_RESP_OKAY, d);
        check("master cleared", 32'h29, d);
        rd(`DHR_OFF_STATUS, `DHR_RESP_OKAY, d);
        check("status nmi", 32'h2, d);
        rd(`DHR_OFF_BLOCK, `DHR_RESP_OKAY, d);
        check("mid block", 32'h1, {31'h0, d[15:8] != 8'h0 && d[15:8] != 8'h8});
        wr(`DHR_OFF_CTRL, 32'h2B, `DHR_RESP_OKAY);
        actFlag <= 1'b1;
        waitClr();
        check("block units", 32'h8, 32'(units - u0));
        actFlag <= 1'b0;
        wr(`DHR_OFF_COUNT, 32'h1, `DHR_RESP_OKAY);
        wr(`DHR_OFF_CTRL, 32'h3, `DHR_RESP_OKAY);
        u0 = units;
        // Request and abort land on one edge, so the pending request dies in a dead cycle.
        actFlag <= 1'b1;
        wr(`DHR_OFF_CTRL, 32'h2, `DHR_RESP_OKAY);
        repeat (4) @(posedge clk);
        check("dead cycles", 32'h1, 32'(deads));
        check("dead no unit", 32'(u0), 32'(units));
        tally_and_finish();
    end
endmodule
